/* hdl/t16ba_top.sv */
// byte-wise cpu access to a 16-bit timer/counter with shared high-byte staging
//
// Summary of operation
// - sixteen-bit registers reached as two byte accesses
// - one eight-bit high-byte staging register
// - staging byte shared by all wide registers
// - low-byte write loads whole register at once
// - low-byte read copies upper half to staging
// - compare reads bypass staging byte
// - clock-select field picks internal or external source
// - counter is sixteen bits, up or down
// - each count strobe moves exactly one step
// - direction signal chooses increment or decrement
// - counter high address reaches the staging byte
// - clock-select zero stops counter, access remains
// - cpu write beats clear and count
`include "t16ba_cfg.svh"
module t16ba_top
  import t16ba_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire t16ba_addr_t cpuAddr,
  input wire logic cpuWrEn,
  input wire logic cpuRdEn,
  input wire t16ba_byte_t cpuWrData,
  output t16ba_byte_t cpuRdData,
  input wire logic prescTick,
  input wire logic extClkPin,
  input wire logic countDown,
  input wire logic countClear,
  input wire logic captureLoad,
  output t16ba_word_t countValue,
  output t16ba_word_t compareA,
  output t16ba_word_t compareB,
  output t16ba_word_t captureValue,
  output t16ba_csel_t clockSelect
);

  t16ba_cnt_if cntLink ();

  t16ba_byte_t staging_q;
  t16ba_word_t compareA_q;
  t16ba_word_t compareB_q;
  t16ba_word_t capture_q;
  t16ba_csel_t clockSel_q;
  t16ba_byte_t rdData_q;
  t16ba_byte_t rdData_d;
  logic extPinS1_q;
  logic extPinS2_q;
  logic extPinPrev_q;
  logic extRise;
  logic extFall;
  logic timerTick;
  logic wrCntLo;
  logic wrCmpALo;
  logic wrCmpBLo;
  logic wrCapLo;
  logic wrCtrl2;
  logic wrHigh;
  logic rdCntLo;
  logic rdCapLo;
  t16ba_word_t wideWrite;

  // address decode of the byte bus
  assign wrCntLo = cpuWrEn && (cpuAddr == `T16BA_OFS_CNT_LO);
  assign wrCmpALo = cpuWrEn && (cpuAddr == `T16BA_OFS_CMPA_LO);
  assign wrCmpBLo = cpuWrEn && (cpuAddr == `T16BA_OFS_CMPB_LO);
  assign wrCapLo = cpuWrEn && (cpuAddr == `T16BA_OFS_CAP_LO);
  assign wrCtrl2 = cpuWrEn && (cpuAddr == `T16BA_OFS_CTRL2);
  assign wrHigh = cpuWrEn && (cpuAddr == `T16BA_OFS_CNT_HI || cpuAddr == `T16BA_OFS_CMPA_HI
    || cpuAddr == `T16BA_OFS_CMPB_HI || cpuAddr == `T16BA_OFS_CAP_HI);
  assign rdCntLo = cpuRdEn && (cpuAddr == `T16BA_OFS_CNT_LO);
  assign rdCapLo = cpuRdEn && (cpuAddr == `T16BA_OFS_CAP_LO);

  // staged high byte joined with the written low byte
  assign wideWrite = {staging_q, cpuWrData};

  // the one shared staging byte
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      staging_q <= `T16BA_BYTE_RST;
    end else if (wrHigh) begin
      staging_q <= cpuWrData;
    end else if (rdCntLo) begin
      staging_q <= cntLink.value[15:8];
    end else if (rdCapLo) begin
      staging_q <= capture_q[15:8];
    end
  end

  // compare registers load only on their low-byte write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      compareA_q <= `T16BA_WORD_RST;
      compareB_q <= `T16BA_WORD_RST;
    end else begin
      if (wrCmpALo) begin
        compareA_q <= wideWrite;
      end
      if (wrCmpBLo) begin
        compareB_q <= wideWrite;
      end
    end
  end

  // capture register: cpu write beats a hardware capture
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      capture_q <= `T16BA_WORD_RST;
    end else if (wrCapLo) begin
      capture_q <= wideWrite;
    end else if (captureLoad) begin
      capture_q <= cntLink.value;
    end
  end

  // second control register, clock-select field only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clockSel_q <= `T16BA_CS_RST;
    end else if (wrCtrl2) begin
      clockSel_q <= cpuWrData[`T16BA_CS_MSB:`T16BA_CS_LSB];
    end
  end

  // read multiplexer; compare bytes come straight from their registers
  always_comb begin
    rdData_d = `T16BA_BYTE_RST;
    unique case (cpuAddr)
      `T16BA_OFS_CNT_LO: rdData_d = cntLink.value[7:0];
      `T16BA_OFS_CNT_HI: rdData_d = staging_q;
      `T16BA_OFS_CMPA_LO: rdData_d = compareA_q[7:0];
      `T16BA_OFS_CMPA_HI: rdData_d = compareA_q[15:8];
      `T16BA_OFS_CMPB_LO: rdData_d = compareB_q[7:0];
      `T16BA_OFS_CMPB_HI: rdData_d = compareB_q[15:8];
      `T16BA_OFS_CAP_LO: rdData_d = capture_q[7:0];
      `T16BA_OFS_CAP_HI: rdData_d = staging_q;
      `T16BA_OFS_CTRL2: rdData_d = {5'h00, clockSel_q};
      default: rdData_d = `T16BA_BYTE_RST; // unmapped reads as zero
    endcase
  end

  // read data registered, valid the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdData_q <= `T16BA_BYTE_RST;
    end else if (cpuRdEn) begin
      rdData_q <= rdData_d;
    end
  end

  // external clock pin: two-stage synchroniser then edge history
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      extPinS1_q <= 1'b0;
      extPinS2_q <= 1'b0;
      extPinPrev_q <= 1'b0;
    end else begin
      extPinS1_q <= extClkPin;
      extPinS2_q <= extPinS1_q;
      extPinPrev_q <= extPinS2_q;
    end
  end

  assign extRise = extPinS2_q && !extPinPrev_q;
  assign extFall = !extPinS2_q && extPinPrev_q;

  // clock-select logic; code zero gives no tick at all
  always_comb begin
    timerTick = 1'b0;
    unique case (clockSel_q)
      `T16BA_CS_STOP: timerTick = 1'b0;
      `T16BA_CS_SYS: timerTick = 1'b1;
      `T16BA_CS_EXT_FALL: timerTick = extFall;
      `T16BA_CS_EXT_RISE: timerTick = extRise;
      default: timerTick = prescTick; // prescaled internal taps
    endcase
  end

  // drive the counter core
  assign cntLink.tick = timerTick;
  assign cntLink.down = countDown;
  assign cntLink.clear = countClear;
  assign cntLink.wrEn = wrCntLo;
  assign cntLink.wrData = wideWrite;

  t16ba_counter_core u_core (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cnt(cntLink.core)
  );

  // outputs
  assign cpuRdData = rdData_q;
  assign countValue = cntLink.value;
  assign compareA = compareA_q;
  assign compareB = compareB_q;
  assign captureValue = capture_q;
  assign clockSelect = clockSel_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_low_write_load: assert property (wrCntLo
    |=> countValue == {$past(staging_q), $past(cpuWrData)})
    else $error("low-byte write did not load the full counter");
  chk_shared_staging: assert property (cpuWrEn && cpuAddr == `T16BA_OFS_CMPB_HI ##1 wrCmpALo
    |=> compareA == {$past(cpuWrData, 2), $past(cpuWrData)})
    else $error("staging byte not shared between registers");
  chk_read_copy_high: assert property (rdCntLo && !cpuWrEn
    |=> staging_q == $past(countValue[15:8]))
    else $error("low-byte read did not stage the upper half");
  chk_compare_bypass: assert property (cpuRdEn && !cpuWrEn && cpuAddr == `T16BA_OFS_CMPA_HI
    |=> $stable(staging_q) && cpuRdData == $past(compareA[15:8]))
    else $error("compare read touched staging or returned wrong byte");
  chk_high_write_only: assert property (cpuWrEn && cpuAddr == `T16BA_OFS_CMPB_HI
    |=> staging_q == $past(cpuWrData) && $stable(compareB))
    else $error("high-byte write changed more than staging");
  chk_counter_high_addr: assert property (cpuRdEn && cpuAddr == `T16BA_OFS_CNT_HI
    |=> cpuRdData == $past(staging_q))
    else $error("counter high read did not return staging byte");
  chk_stopped_frozen: assert property (clockSel_q == `T16BA_CS_STOP && !wrCntLo && !countClear
    |=> $stable(countValue))
    else $error("stopped counter moved");
  chk_sys_clock_counts: assert property (clockSel_q == `T16BA_CS_SYS && !wrCntLo && !countClear
    && !countDown |=> countValue == $past(countValue) + 16'h0001)
    else $error("system clock select did not count");
  cov_wide_write: cover property (wrHigh ##1 wrCntLo);
  cov_wide_read: cover property (rdCntLo ##1 cpuRdEn && cpuAddr == `T16BA_OFS_CNT_HI);
  cov_ext_tick: cover property (clockSel_q == `T16BA_CS_EXT_RISE && extRise);
endmodule

/* hdl/t16ba_cfg.svh */
// constants of the byte-access 16-bit timer: offsets, fields, resets, codes
`ifndef T16BA_CFG_SVH
`define T16BA_CFG_SVH

// byte addresses on the cpu byte bus
`define T16BA_OFS_CNT_LO 4'h0
`define T16BA_OFS_CNT_HI 4'h1
`define T16BA_OFS_CMPA_LO 4'h2
`define T16BA_OFS_CMPA_HI 4'h3
`define T16BA_OFS_CMPB_LO 4'h4
`define T16BA_OFS_CMPB_HI 4'h5
`define T16BA_OFS_CAP_LO 4'h6
`define T16BA_OFS_CAP_HI 4'h7
`define T16BA_OFS_CTRL2 4'h8

// clock-select field of the second control register
`define T16BA_CS_LSB 0
`define T16BA_CS_MSB 2

// reset values
`define T16BA_WORD_RST 16'h0000
`define T16BA_BYTE_RST 8'h00
`define T16BA_CS_RST 3'h0

// clock-select codes
`define T16BA_CS_STOP 3'h0
`define T16BA_CS_SYS 3'h1
`define T16BA_CS_PRESC_FIRST 3'h2
`define T16BA_CS_PRESC_LAST 3'h5
`define T16BA_CS_EXT_FALL 3'h6
`define T16BA_CS_EXT_RISE 3'h7

`endif

/* hdl/t16ba_pkg.sv */
// types shared by the byte-access 16-bit timer modules
package t16ba_pkg;
  typedef logic [15:0] t16ba_word_t;
  typedef logic [7:0] t16ba_byte_t;
  typedef logic [3:0] t16ba_addr_t;
  typedef logic [2:0] t16ba_csel_t;
endpackage

/* hdl/t16ba_cnt_if.sv */
// link between the access logic and the counter core
interface t16ba_cnt_if;
  import t16ba_pkg::*;
  logic tick;
  logic down;
  logic clear;
  logic wrEn;
  t16ba_word_t wrData;
  t16ba_word_t value;
  modport ctl (output tick, output down, output clear, output wrEn, output wrData,
    input value);
  modport core (input tick, input down, input clear, input wrEn, input wrData,
    output value);
endinterface

/* hdl/t16ba_counter_core.sv */
// 16-bit bidirectional counter core with cpu load priority
`include "t16ba_cfg.svh"
module t16ba_counter_core
  import t16ba_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  t16ba_cnt_if.core cnt
);

  t16ba_word_t value_q;

  // load beats clear beats count; one step per tick
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      value_q <= `T16BA_WORD_RST;
    end else if (cnt.wrEn) begin
      value_q <= cnt.wrData;
    end else if (cnt.clear) begin
      value_q <= `T16BA_WORD_RST;
    end else if (cnt.tick) begin
      if (cnt.down) begin
        value_q <= value_q - 16'h0001;
      end else begin
        value_q <= value_q + 16'h0001;
      end
    end
  end

  assign cnt.value = value_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_write_wins_all: assert property (cnt.wrEn |=> cnt.value == $past(cnt.wrData))
    else $error("cpu load did not win over clear or count");
  chk_step_by_one: assert property (!cnt.wrEn && !cnt.clear && cnt.tick
    |=> cnt.value == ($past(cnt.down) ? $past(cnt.value) - 16'h0001
    : $past(cnt.value) + 16'h0001))
    else $error("counter step was not exactly one");
  chk_hold_no_tick: assert property (!cnt.wrEn && !cnt.clear && !cnt.tick
    |=> $stable(cnt.value))
    else $error("counter moved without a tick");
  cov_count_down: cover property (cnt.tick && cnt.down && !cnt.wrEn ##1 cnt.tick && cnt.down);
endmodule

/* sim/t16ba_cpu_model.sv */
// cpu core model: byte bus master doing wide timer accesses
module t16ba_cpu_model
  import t16ba_pkg::*;
(
  input wire logic core_clk,
  output t16ba_addr_t cpuAddr,
  output logic cpuWrEn,
  output logic cpuRdEn,
  output t16ba_byte_t cpuWrData,
  input wire t16ba_byte_t cpuRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus quiet at time zero
  initial begin
    cpuAddr = 4'h0;
    cpuWrEn = 1'b0;
    cpuRdEn = 1'b0;
    cpuWrData = 8'hA5;
  end
  // one byte cycle: launched at an edge, taken at the next one
  task automatic op(input logic we, input logic re, input t16ba_addr_t a, input t16ba_byte_t d);
    cpuWrEn <= we;
    cpuRdEn <= re;
    cpuAddr <= a;
    cpuWrData <= d;
    @(posedge core_clk);
  endtask
  // strobes off, data lines keep toggling
  task automatic idle();
    op(1'b0, 1'b0, cpuAddr, ~cpuWrData);
  endtask
  task automatic wr8(input t16ba_addr_t a, input t16ba_byte_t d);
    op(1'b1, 1'b0, a, d);
    idle();
  endtask
  task automatic rd8(input t16ba_addr_t a, output t16ba_byte_t d);
    op(1'b0, 1'b1, a, cpuWrData);
    idle();
    d = cpuRdData;
  endtask
  // wide write as two byte cycles, never interleaved with another access
  task automatic wr16(input t16ba_addr_t lo, input t16ba_word_t v);
    op(1'b1, 1'b0, lo + 4'h1, v[15:8]);
    op(1'b1, 1'b0, lo, v[7:0]);
    idle();
  endtask
  // wide read, low byte first, high byte right after
  task automatic rd16(input t16ba_addr_t lo, output t16ba_word_t v);
    op(1'b0, 1'b1, lo, cpuWrData);
    op(1'b0, 1'b1, lo + 4'h1, cpuWrData);
    v[7:0] = cpuRdData;
    idle();
    v[15:8] = cpuRdData;
  endtask
endmodule

/* sim/tb_timer16_byte_access_counter.sv */
// self-checking bench of the byte-access 16-bit timer
`include "t16ba_cfg.svh"
`define CHK(n, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); \
  end \
end
module tb_timer16_byte_access_counter
  import t16ba_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n, cpuWrEn, cpuRdEn, prescTick, extClkPin, countDown, countClear;
  logic captureLoad;
  t16ba_addr_t cpuAddr;
  t16ba_byte_t cpuWrData, cpuRdData, b;
  t16ba_word_t countValue, compareA, compareB, captureValue, v, lf;
  t16ba_word_t ex[4];
  t16ba_csel_t clockSelect;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  // 10 MHz clock
  always #50 core_clk = ~core_clk;
  t16ba_top dut_u (.core_clk, .rst_n, .cpuAddr, .cpuWrEn, .cpuRdEn, .cpuWrData,
    .cpuRdData, .prescTick, .extClkPin, .countDown, .countClear, .captureLoad,
    .countValue, .compareA, .compareB, .captureValue, .clockSelect);
  t16ba_cpu_model cpu_u (.core_clk, .cpuAddr, .cpuWrEn, .cpuRdEn, .cpuWrData,
    .cpuRdData);
  function automatic t16ba_word_t nxt(input t16ba_word_t s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic t16ba_word_t stepv(input t16ba_word_t a, input logic dn);
    return dn ? a - 16'h0001 : a + 16'h0001;
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    finish_test();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    {prescTick, extClkPin, countDown, countClear, captureLoad} = 5'h00;
    lf = 16'h000D;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    `CHK("rstCnt", `T16BA_WORD_RST, countValue)
    // random wide writes to all four wide registers, counter stopped
    for (int i = 0; i < 4; i++) begin
      lf = nxt(lf);
      ex[i] = lf;
      cpu_u.wr16(t16ba_addr_t'(2 * i), lf);
    end
    `CHK("cnt", ex[0], countValue)
    `CHK("cmpA", ex[1], compareA)
    `CHK("cmpB", ex[2], compareB)
    `CHK("cap", ex[3], captureValue)
    repeat (4) @(posedge core_clk);
    `CHK("stopped", ex[0], countValue)
    cpu_u.rd16(`T16BA_OFS_CNT_LO, v);
    `CHK("rdCnt", ex[0], v)
    cpu_u.rd16(`T16BA_OFS_CAP_LO, v);
    `CHK("rdCap", ex[3], v)
    // a second low read overwrites the one staging byte
    cpu_u.op(1'b0, 1'b1, `T16BA_OFS_CNT_LO, 8'h00);
    cpu_u.op(1'b0, 1'b1, `T16BA_OFS_CAP_LO, 8'h00);
    cpu_u.op(1'b0, 1'b1, `T16BA_OFS_CNT_HI, 8'h00);
    cpu_u.idle();
    `CHK("shared", ex[3][15:8], cpuRdData)
    // stage via one register, compare reads in between, land in another
    lf = nxt(lf);
    cpu_u.wr8(`T16BA_OFS_CMPB_HI, lf[15:8]);
    `CHK("hiOnly", ex[2], compareB)
    cpu_u.rd8(`T16BA_OFS_CMPA_HI, b);
    `CHK("cmpHi", ex[1][15:8], b)
    cpu_u.rd8(`T16BA_OFS_CMPA_LO, b);
    `CHK("cmpLo", ex[1][7:0], b)
    cpu_u.rd8(`T16BA_OFS_CNT_HI, b);
    `CHK("stage", lf[15:8], b)
    cpu_u.wr8(`T16BA_OFS_CNT_LO, lf[7:0]);
    `CHK("loneLo", lf, countValue)
    // back-to-back: stage through compare B, land in compare A
    cpu_u.op(1'b1, 1'b0, `T16BA_OFS_CMPB_HI, lf[7:0]);
    cpu_u.op(1'b1, 1'b0, `T16BA_OFS_CMPA_LO, lf[15:8]);
    cpu_u.idle();
    `CHK("xStage", {lf[7:0], lf[15:8]}, compareA)
    `CHK("xStageB", ex[2], compareB)
    // system clock counting up through the wrap, then countDown from lf bits every ten cycles
    cpu_u.wr16(`T16BA_OFS_CNT_LO, 16'hFFF8);
    cpu_u.wr8(`T16BA_OFS_CTRL2, {5'h00, `T16BA_CS_SYS});
    `CHK("csSys", `T16BA_CS_SYS, clockSelect)
    for (int i = 0; i < 40; i++) begin
      if (i % 10 == 0) countDown <= (i == 0) ? 1'b0 : lf[i / 10];
      v = countValue;
      @(posedge core_clk);
      if (i % 10 > 2) `CHK("step", stepv(v, countDown), countValue)
    end
    // cpu write wins over count, then over clear
    cpu_u.wr16(`T16BA_OFS_CNT_LO, 16'h1234);
    `CHK("wrRun", 16'h1234, countValue)
    countClear <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK("clear", 16'h0000, countValue)
    cpu_u.wr16(`T16BA_OFS_CNT_LO, 16'hBEEF);
    `CHK("wrClr", 16'hBEEF, countValue)
    countClear <= 1'b0;
    countDown <= 1'b0;
    // prescaler taps and both pin edges
    for (int cs = 2; cs < 8; cs++) begin
      cpu_u.wr8(`T16BA_OFS_CTRL2, 8'(cs));
      `CHK("cs", 3'(cs), clockSelect)
      v = countValue;
      n = 0;
      for (int i = 0; i < 64; i++) begin
        lf = nxt(lf);
        if (cs < 6) begin
          prescTick <= lf[0];
          n += lf[0];
        end else if (i % 4 == 0 && lf[0]) begin
          extClkPin <= !extClkPin;
          n += (extClkPin == (cs == 6));
        end
        @(posedge core_clk);
      end
      prescTick <= 1'b0;
      repeat (6) @(posedge core_clk);
      `CHK("srcCount", v + 16'(n), countValue)
    end
    // select zero stops the counter
    cpu_u.wr8(`T16BA_OFS_CTRL2, 8'hF8); // upper bits are not stored
    @(posedge core_clk);
    v = countValue;
    repeat (5) @(posedge core_clk);
    `CHK("stop", v, countValue)
    cpu_u.rd8(`T16BA_OFS_CTRL2, b);
    `CHK("ctrlRd", 8'h00, b)
    // hardware capture of the frozen count, then a wide read of it
    captureLoad <= 1'b1;
    @(posedge core_clk);
    captureLoad <= 1'b0;
    cpu_u.rd16(`T16BA_OFS_CAP_LO, ex[0]);
    `CHK("capOut", v, captureValue)
    `CHK("capLoad", v, ex[0])
    finish_test();
  end
endmodule
